/* File: include/ldm_pkg.sv */
/*
 * Shared definitions for the load/multiply opcode decoder: opcode patterns,
 * field positions, word and cycle counts, and the decoded-instruction struct.
 * Assumes a 16-bit instruction word fetched one word per fetch beat.
 */
package ldm_pkg;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int OPC_HI = 15;
	localparam int OPC_UB_LO = 8;
	localparam int OPC_ARX_HI = 2;
	localparam int OPC_PAGE_HI = 8;
	localparam int OPC_SEL_BIT = 3;
	localparam int OPC_SHIFT_HI = 3;
	localparam int OPC_BYTE_HI = 7;
	localparam int OPC_W12_LO = 4;
	localparam int OPC_W7_LO = 9;
	localparam int OPC_W5_LO = 11;
	localparam int OPC_AUXS_HI = 10;

	// ****************************************
	// Opcode patterns
	// ****************************************
	localparam logic [7:0] UB_ACC_IMM = 8'hb9;
	localparam logic [7:0] UB_ACC_HIGH = 8'h6a;
	localparam logic [7:0] UB_ACC_LOWNS = 8'h69;
	localparam logic [7:0] UB_ACC_TSHIFT = 8'h6b;
	localparam logic [4:0] UB5_AUX_SHORT = 5'h16;
	localparam logic [11:0] W12_AUX_LONG = 12'hbf0;
	localparam logic [6:0] UB7_PAGE_IMM = 7'h5e;
	localparam logic [7:0] UB_PAGE_MEM = 8'h0d;
	localparam logic [7:0] UB_STAT0 = 8'h0e;
	localparam logic [7:0] UB_STAT1 = 8'h0f;
	localparam logic [7:0] UB_LT_ACC = 8'h70;
	localparam logic [7:0] UB_LT_MOVE = 8'h72;
	localparam logic [7:0] UB_LT_PROD = 8'h71;
	localparam logic [7:0] UB_LT_SUB = 8'h74;
	localparam logic [7:0] UB_MUL_ACC = 8'ha2;
	localparam logic [7:0] UB_MUL_ACC_MOVE = 8'ha3;
	localparam logic [11:0] W12_AUX_PTR = 12'h8b8;
	localparam logic [7:0] UB_MODIFY_AUX = 8'h8b;
	localparam logic [7:0] UB_MULTIPLY = 8'h54;
	localparam logic [7:0] UB_MUL_ADD = 8'h50;
	localparam logic [7:0] UB_MUL_SUB = 8'h51;
	localparam logic [7:0] UB_NORMALIZE = 8'ha0;
	localparam logic [11:0] W12_OR_SHIFT = 12'hbfc;
	localparam logic [15:0] W16_OR_SHIFT16 = 16'hbe82;
	localparam logic [15:0] W16_PROD_TO_ACC = 16'hbe03;

	// ****************************************
	// Word, cycle and shift counts
	// ****************************************
	localparam logic [1:0] WORDS_ONE = 2'h1;
	localparam logic [1:0] WORDS_TWO = 2'h2;
	localparam logic [1:0] CYC_ONE = 2'h1;
	localparam logic [1:0] CYC_TWO = 2'h2;
	localparam logic [1:0] CYC_THREE = 2'h3;
	localparam logic [4:0] SHIFT_SIXTEEN = 5'h10;

	// Operation codes produced by the decoder
	typedef enum logic [4:0] {
		LDM_OP_NONE = 5'h00,
		LDM_OP_LOAD_ACC_IMM = 5'h01,
		LDM_OP_LOAD_ACC_HIGH = 5'h02,
		LDM_OP_LOAD_ACC_LOW = 5'h03,
		LDM_OP_LOAD_ACC_TSHIFT = 5'h04,
		LDM_OP_LOAD_AUX_SHORT = 5'h05,
		LDM_OP_LOAD_AUX_LONG = 5'h06,
		LDM_OP_LOAD_PAGE_IMM = 5'h07,
		LDM_OP_LOAD_PAGE_MEM = 5'h08,
		LDM_OP_LOAD_STAT0 = 5'h09,
		LDM_OP_LOAD_STAT1 = 5'h0a,
		LDM_OP_LOAD_T_ACC = 5'h0b,
		LDM_OP_LOAD_T_MOVE = 5'h0c,
		LDM_OP_LOAD_T_PROD = 5'h0d,
		LDM_OP_LOAD_T_SUB = 5'h0e,
		LDM_OP_MUL_ACC = 5'h0f,
		LDM_OP_MUL_ACC_MOVE = 5'h10,
		LDM_OP_LOAD_AUX_PTR = 5'h11,
		LDM_OP_MODIFY_AUX = 5'h12,
		LDM_OP_MULTIPLY = 5'h13,
		LDM_OP_MUL_ADD_PREV = 5'h14,
		LDM_OP_MUL_SUB_PREV = 5'h15,
		LDM_OP_NORMALIZE = 5'h16,
		LDM_OP_OR_SHIFT = 5'h17,
		LDM_OP_OR_SHIFT16 = 5'h18,
		LDM_OP_PROD_TO_ACC = 5'h19
	} ldm_op_t;

	// One decoded instruction as handed to the execution units
	typedef struct packed {
		ldm_op_t op;
		logic [1:0] words;
		logic [1:0] cycles;
		logic [7:0] operand_address_byte;
		logic [8:0] immediate;
		logic [2:0] aux_reg_select;
		logic [4:0] shift_count;
		logic [15:0] second_word;
	} ldm_dec_t;

endpackage

/* File: hw/ldm_word_reg.sv */
/*
 * Holding register for one fetched instruction word; data leave from a flop.
 * Assumes a synchronous active-low reset and a single clock.
 */
`timescale 1ns/1ps
module ldm_word_reg (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// Write side
	input wire logic i_load,
	input wire logic [15:0] i_word,
	// Read side
	output logic [15:0] o_word
);

	// Capture the word when loaded
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_word <= 16'h0000;
		end else if (i_load) begin
			o_word <= i_word;
		end
	end

endmodule

/* File: hw/ldm_decode.sv */
/*
 * Opcode decoder for the load, T-register and multiply group of a 16-bit
 * fixed-point DSP core. Takes fetched words with a valid/ready handshake and
 * emits one decoded instruction per opcode, with its word and cycle counts.
 * Assumes the fetch path supplies consecutive program words in order.
 */
// What this block does
// - b9 plus 8-bit constant: load accumulator short immediate, 1 word 1 cycle
// - Upper byte 6a: zero low accumulator, load high half, 1 word 1 cycle
// - Upper byte 69: zero accumulator, load low unsigned, 1 word 1 cycle
// - Upper byte 6b: load accumulator shifted by T register, 1/1
// - 1011 0ARx plus constant: load auxiliary register short, 1 word 2 cycles
// - bf0 1ARx plus constant word: load auxiliary register long, 2/2
// - 1011 110 plus 9 bits loads page pointer; 0d from memory; 1/2
// - Upper bytes 0e and 0f load status registers zero and one, 1/2
// - Upper byte 70: load T, accumulate previous product, 1/1
// - Upper byte 72: load T, accumulate, move data, 1/1
// - Upper byte 71: load T, product into accumulator, 1/1
// - Upper byte 74: load T, subtract previous product, 1/1
// - Upper byte a2 plus constant word: multiply and accumulate, 2/3
// - Upper byte a3 plus constant word: multiply accumulate with move, 2/3
// - 8b8 1ARx loads aux pointer; other 8b modifies aux; one cycle
// - Upper byte 54: multiply T by operand into product, 1/1
// - Upper byte 50: add previous product, new multiply, 1/1
// - Upper byte 51: subtract previous product, new multiply, 1/1
// - Upper byte a0: normalize accumulator, 1/1
// - bfc plus shift, then constant: OR shifted constant, 2/2
// - be82 then constant: OR constant shifted by 16, 2/2
// - be03: copy product register to accumulator, 1/1
// - Block move is unreliable on interrupt and global registers; software avoids it
`timescale 1ns/1ps
module ldm_decode (
	// Clock and reset
	input wire logic I_CLOCK,
	input wire logic I_NRST,
	// Fetch side
	input wire logic I_FETCH_VALID,
	input wire logic [15:0] I_FETCH_WORD,
	output logic O_FETCH_READY,
	// Execution side
	output logic O_DEC_VALID,
	output ldm_pkg::ldm_dec_t O_DEC,
	output logic O_DEC_UNKNOWN,
	input wire logic I_EXEC_READY
);

	// ****************************************
	// State machine
	// ****************************************
	typedef enum logic [2:0] {
		LDM_ST_FIRST = 3'b001,
		LDM_ST_SECOND = 3'b010,
		LDM_ST_OUT = 3'b100
	} ldm_state_t;

	ldm_state_t state;
	ldm_state_t next_state;
	ldm_pkg::ldm_dec_t dec;
	ldm_pkg::ldm_dec_t next_dec;
	logic next_unknown;
	logic unknown;
	logic [15:0] held_word;
	logic take;
	logic [15:0] w;
	logic [7:0] ub;
	logic [11:0] w12;
	logic [6:0] w7;
	logic [4:0] w5;

	assign w = I_FETCH_WORD;
	assign ub = w[ldm_pkg::OPC_HI:ldm_pkg::OPC_UB_LO];
	// Leading fields of different lengths for the prefix matches
	assign w12 = w[ldm_pkg::OPC_HI:ldm_pkg::OPC_W12_LO];
	assign w7 = w[ldm_pkg::OPC_HI:ldm_pkg::OPC_W7_LO];
	assign w5 = w[ldm_pkg::OPC_HI:ldm_pkg::OPC_W5_LO];
	assign take = I_FETCH_VALID && O_FETCH_READY;

	// ****************************************
	// First-word decode
	// ****************************************
	// Classify the first word and fill the fields
	always_comb begin
		next_unknown = 1'b0;
		next_dec = '0;
		next_dec.op = ldm_pkg::LDM_OP_NONE;
		next_dec.words = ldm_pkg::WORDS_ONE;
		next_dec.cycles = ldm_pkg::CYC_ONE;
		next_dec.operand_address_byte = w[ldm_pkg::OPC_BYTE_HI:0];
		next_dec.aux_reg_select = w[ldm_pkg::OPC_ARX_HI:0];
		next_dec.shift_count = {1'b0, w[ldm_pkg::OPC_SHIFT_HI:0]};
		if (w == ldm_pkg::W16_PROD_TO_ACC) begin
			next_dec.op = ldm_pkg::LDM_OP_PROD_TO_ACC;
		end else if (w == ldm_pkg::W16_OR_SHIFT16) begin
			next_dec.op = ldm_pkg::LDM_OP_OR_SHIFT16;
			next_dec.words = ldm_pkg::WORDS_TWO;
			next_dec.cycles = ldm_pkg::CYC_TWO;
			next_dec.shift_count = ldm_pkg::SHIFT_SIXTEEN;
		end else if (w12 == ldm_pkg::W12_OR_SHIFT) begin
			next_dec.op = ldm_pkg::LDM_OP_OR_SHIFT;
			next_dec.words = ldm_pkg::WORDS_TWO;
			next_dec.cycles = ldm_pkg::CYC_TWO;
		end else if (w12 == ldm_pkg::W12_AUX_LONG && w[ldm_pkg::OPC_SEL_BIT]) begin
			next_dec.op = ldm_pkg::LDM_OP_LOAD_AUX_LONG;
			next_dec.words = ldm_pkg::WORDS_TWO;
			next_dec.cycles = ldm_pkg::CYC_TWO;
		end else if (w12 == ldm_pkg::W12_AUX_PTR && w[ldm_pkg::OPC_SEL_BIT]) begin
			next_dec.op = ldm_pkg::LDM_OP_LOAD_AUX_PTR;
		end else if (w7 == ldm_pkg::UB7_PAGE_IMM) begin
			next_dec.op = ldm_pkg::LDM_OP_LOAD_PAGE_IMM;
			next_dec.cycles = ldm_pkg::CYC_TWO;
			next_dec.immediate = w[ldm_pkg::OPC_PAGE_HI:0];
		end else if (w5 == ldm_pkg::UB5_AUX_SHORT) begin
			next_dec.op = ldm_pkg::LDM_OP_LOAD_AUX_SHORT;
			next_dec.cycles = ldm_pkg::CYC_TWO;
			next_dec.aux_reg_select = w[ldm_pkg::OPC_AUXS_HI:ldm_pkg::OPC_UB_LO];
			next_dec.immediate = {1'b0, w[ldm_pkg::OPC_BYTE_HI:0]};
		end else begin
			case (ub)
				ldm_pkg::UB_ACC_IMM: begin
					// Zero constant clears the accumulator
					next_dec.op = ldm_pkg::LDM_OP_LOAD_ACC_IMM;
					next_dec.immediate = {1'b0, w[ldm_pkg::OPC_BYTE_HI:0]};
				end
				ldm_pkg::UB_ACC_HIGH: next_dec.op = ldm_pkg::LDM_OP_LOAD_ACC_HIGH;
				ldm_pkg::UB_ACC_LOWNS: next_dec.op = ldm_pkg::LDM_OP_LOAD_ACC_LOW;
				ldm_pkg::UB_ACC_TSHIFT: next_dec.op = ldm_pkg::LDM_OP_LOAD_ACC_TSHIFT;
				ldm_pkg::UB_PAGE_MEM: begin
					next_dec.op = ldm_pkg::LDM_OP_LOAD_PAGE_MEM;
					next_dec.cycles = ldm_pkg::CYC_TWO;
				end
				ldm_pkg::UB_STAT0: begin
					next_dec.op = ldm_pkg::LDM_OP_LOAD_STAT0;
					next_dec.cycles = ldm_pkg::CYC_TWO;
				end
				ldm_pkg::UB_STAT1: begin
					next_dec.op = ldm_pkg::LDM_OP_LOAD_STAT1;
					next_dec.cycles = ldm_pkg::CYC_TWO;
				end
				ldm_pkg::UB_LT_ACC: next_dec.op = ldm_pkg::LDM_OP_LOAD_T_ACC;
				ldm_pkg::UB_LT_MOVE: next_dec.op = ldm_pkg::LDM_OP_LOAD_T_MOVE;
				ldm_pkg::UB_LT_PROD: next_dec.op = ldm_pkg::LDM_OP_LOAD_T_PROD;
				ldm_pkg::UB_LT_SUB: next_dec.op = ldm_pkg::LDM_OP_LOAD_T_SUB;
				ldm_pkg::UB_MUL_ACC: begin
					next_dec.op = ldm_pkg::LDM_OP_MUL_ACC;
					next_dec.words = ldm_pkg::WORDS_TWO;
					next_dec.cycles = ldm_pkg::CYC_THREE;
				end
				ldm_pkg::UB_MUL_ACC_MOVE: begin
					next_dec.op = ldm_pkg::LDM_OP_MUL_ACC_MOVE;
					next_dec.words = ldm_pkg::WORDS_TWO;
					next_dec.cycles = ldm_pkg::CYC_THREE;
				end
				ldm_pkg::UB_MODIFY_AUX: next_dec.op = ldm_pkg::LDM_OP_MODIFY_AUX;
				ldm_pkg::UB_MULTIPLY: next_dec.op = ldm_pkg::LDM_OP_MULTIPLY;
				ldm_pkg::UB_MUL_ADD: next_dec.op = ldm_pkg::LDM_OP_MUL_ADD_PREV;
				ldm_pkg::UB_MUL_SUB: next_dec.op = ldm_pkg::LDM_OP_MUL_SUB_PREV;
				ldm_pkg::UB_NORMALIZE: next_dec.op = ldm_pkg::LDM_OP_NORMALIZE;
				// Block moves and all else outside the group: no operation, flagged
				default: next_unknown = 1'b1;
			endcase
		end
	end

	// ****************************************
	// Sequencing
	// ****************************************
	// Fetch ready whenever no decoded result is waiting
	assign O_FETCH_READY = (state != LDM_ST_OUT);

	// Next state: a two-word opcode waits for the following word
	always_comb begin
		next_state = state;
		case (state)
			LDM_ST_FIRST: begin
				if (take) begin
					if (!next_unknown && next_dec.words == ldm_pkg::WORDS_TWO) begin
						next_state = LDM_ST_SECOND;
					end else begin
						next_state = LDM_ST_OUT;
					end
				end
			end
			LDM_ST_SECOND: begin
				if (take) begin
					next_state = LDM_ST_OUT;
				end
			end
			LDM_ST_OUT: begin
				if (I_EXEC_READY) begin
					next_state = LDM_ST_FIRST;
				end
			end
			default: next_state = LDM_ST_FIRST;
		endcase
	end

	// State register
	always_ff @(posedge I_CLOCK) begin
		if (!I_NRST) begin
			state <= LDM_ST_FIRST;
		end else begin
			state <= next_state;
		end
	end

	// Decoded result captured from the first word
	always_ff @(posedge I_CLOCK) begin
		if (!I_NRST) begin
			dec <= '0;
			unknown <= 1'b0;
		end else if (take && state == LDM_ST_FIRST) begin
			dec <= next_dec;
			unknown <= next_unknown;
		end
	end

	// Second word held in its own register, taken from the next program address
	ldm_word_reg u_second (
		.i_clk(I_CLOCK),
		.i_nrst(I_NRST),
		.i_load(take && state == LDM_ST_SECOND),
		.i_word(I_FETCH_WORD),
		.o_word(held_word)
	);

	// ****************************************
	// Outputs
	// ****************************************
	// Result with the second word merged in
	always_comb begin
		O_DEC = dec;
		O_DEC.second_word = held_word;
	end
	assign O_DEC_VALID = (state == LDM_ST_OUT);
	assign O_DEC_UNKNOWN = unknown;

endmodule

/* File: bench/ldm_props.sv */
/*
 * Port checker for the load/multiply opcode decoder.
 * Assumes it is bound to ldm_decode and sees only its ports.
 */
`timescale 1ns/1ps
module ldm_props (
	// Clock and reset
	input wire logic I_CLOCK,
	input wire logic I_NRST,
	// Fetch side
	input wire logic I_FETCH_VALID,
	input wire logic [15:0] I_FETCH_WORD,
	input wire logic O_FETCH_READY,
	// Execution side
	input wire logic O_DEC_VALID,
	input wire ldm_pkg::ldm_dec_t O_DEC,
	input wire logic O_DEC_UNKNOWN,
	input wire logic I_EXEC_READY
);
	// ****************
	// Word tracking
	// ****************
	logic tk;
	logic sec;
	logic [15:0] fw;
	// True for first words that need a second word
	function automatic logic two(input logic [15:0] w);
		return w[15:9] == 7'h51 || w[15:3] == 13'h17e1 || w[15:4] == 12'hbfc || w == 16'hbe82;
	endfunction
	assign tk = I_FETCH_VALID && O_FETCH_READY;
	// Second word pending flag
	always_ff @(posedge I_CLOCK) begin
		if (!I_NRST)
			sec <= 1'b0;
		else if (tk)
			sec <= !sec && two(I_FETCH_WORD);
	end
	// First word of the instruction in flight
	always_ff @(posedge I_CLOCK) begin
		if (tk && !sec)
			fw <= I_FETCH_WORD;
	end
	default clocking @(posedge I_CLOCK); endclocking
	default disable iff (!I_NRST);
	// ****************
	// Properties
	// ****************
	a_fetch_refused: assert property (O_DEC_VALID |-> !O_FETCH_READY)
		else $error("word accepted while a result waits");
	a_dec_holds: assert property (O_DEC_VALID && !I_EXEC_READY
		|=> O_DEC_VALID && $stable(O_DEC))
		else $error("result changed before being taken");
	a_taken_clears: assert property (O_DEC_VALID && I_EXEC_READY |=> !O_DEC_VALID)
		else $error("result stayed after being taken");
	a_one_word_ans: assert property (tk && !sec && !two(I_FETCH_WORD) |=> O_DEC_VALID)
		else $error("one-word result late");
	a_second_wait: assert property (tk && !sec && two(I_FETCH_WORD) |=> !O_DEC_VALID)
		else $error("two-word result before second word");
	a_second_word: assert property (tk && sec |=> O_DEC_VALID && O_DEC.words == 2'h2
		&& O_DEC.second_word == $past(I_FETCH_WORD))
		else $error("second word not paired");
	a_mul_acc_counts: assert property (tk && sec && fw[15:8] == 8'ha2
		|=> O_DEC.op == ldm_pkg::LDM_OP_MUL_ACC && O_DEC.cycles == 2'h3)
		else $error("multiply accumulate counts wrong");
	a_acc_high: assert property (tk && !sec && I_FETCH_WORD[15:8] == 8'h6a
		|=> O_DEC.op == ldm_pkg::LDM_OP_LOAD_ACC_HIGH && O_DEC.cycles == 2'h1)
		else $error("high accumulator load wrong");
	a_page_imm: assert property (tk && !sec && I_FETCH_WORD[15:9] == 7'h5e
		|=> O_DEC.immediate == $past(I_FETCH_WORD[8:0]) && O_DEC.cycles == 2'h2)
		else $error("page immediate wrong");
	a_aux_short: assert property (tk && !sec && I_FETCH_WORD[15:11] == 5'h16
		|=> O_DEC.op == ldm_pkg::LDM_OP_LOAD_AUX_SHORT && O_DEC.cycles == 2'h2
		&& O_DEC.aux_reg_select == $past(I_FETCH_WORD[10:8]))
		else $error("short auxiliary load wrong");
	a_unknown_none: assert property (O_DEC_VALID && O_DEC_UNKNOWN
		|-> O_DEC.op == ldm_pkg::LDM_OP_NONE)
		else $error("unknown word with an operation");
	// Main scenarios
	c_two_word: cover property (tk && sec);
	c_unknown: cover property (O_DEC_VALID && O_DEC_UNKNOWN);
	c_stall: cover property (O_DEC_VALID && !I_EXEC_READY ##1 O_DEC_VALID);
endmodule

bind ldm_decode ldm_props i_props (.I_CLOCK(I_CLOCK), .I_NRST(I_NRST),
	.I_FETCH_VALID(I_FETCH_VALID), .I_FETCH_WORD(I_FETCH_WORD), .O_FETCH_READY(O_FETCH_READY),
	.O_DEC_VALID(O_DEC_VALID), .O_DEC(O_DEC), .O_DEC_UNKNOWN(O_DEC_UNKNOWN),
	.I_EXEC_READY(I_EXEC_READY));

/* File: bench/ldm_fetch_model.sv */
/*
 * Program memory fetch path model: offers words in address order.
 * Assumes the bench fills prog and i_count before the run.
 */
`timescale 1ns/1ps
module ldm_fetch_model (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// Bench control
	input wire logic i_stall,
	input wire logic [7:0] i_count,
	// Fetch handshake
	input wire logic i_ready,
	output logic o_valid,
	output logic [15:0] o_word
);
	logic [15:0] prog [0:255];
	logic [7:0] ptr = 8'h00;
	logic taken = 1'b0;
	initial begin
		o_valid = 1'b0;
		o_word = 16'h0000;
	end
	// Step to the next program address once a word is taken
	always @(posedge i_clk) begin
		taken = o_valid && i_ready && i_nrst;
		if (taken)
			ptr <= ptr + 8'h01;
	end
	// Hold each word until taken; a released line toggles
	always @(negedge i_clk) begin
		if (!o_valid || taken) begin
			if (ptr < i_count && !i_stall && i_nrst) begin
				o_valid <= 1'b1;
				o_word <= prog[ptr];
			end else begin
				o_valid <= 1'b0;
				o_word <= ~o_word;
			end
		end
	end
endmodule

/* File: bench/testbench.sv */
/*
 * Self-checking bench for the opcode decoder with random stalls.
 * Assumes ldm_pkg, ldm_decode, ldm_fetch_model and ldm_props.
 */
`timescale 1ns/1ps
module testbench;
	typedef struct packed {
		ldm_pkg::ldm_op_t op;
		logic [3:0] wc;
		logic u;
		logic [15:0] s;
		logic [15:0] f;
	} ldm_exp_t;
	logic i_clock = 1'b0;
	logic i_nrst = 1'b0;
	logic exec_ready = 1'b0;
	logic stall = 1'b0;
	logic [7:0] count = 8'h00;
	logic fvalid;
	logic fready;
	logic dvalid;
	logic dunk;
	logic [15:0] fword;
	ldm_pkg::ldm_dec_t dec;
	ldm_exp_t expq[$];
	logic [31:0] rnd = 32'd87263;
	int bad_count = 0;
	int total_checks = 0;
	int n = 0;
	int k;

	ldm_decode i_dut (.I_CLOCK(i_clock), .I_NRST(i_nrst), .I_FETCH_VALID(fvalid),
		.I_FETCH_WORD(fword), .O_FETCH_READY(fready), .O_DEC_VALID(dvalid), .O_DEC(dec),
		.O_DEC_UNKNOWN(dunk), .I_EXEC_READY(exec_ready));
	ldm_fetch_model i_mem (.i_clk(i_clock), .i_nrst(i_nrst), .i_stall(stall), .i_count(count),
		.i_ready(fready), .o_valid(fvalid), .o_word(fword));

	// Clock
	always #2.5 i_clock = ~i_clock;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Place one instruction in memory and note its expected decode
	task automatic add(input logic [15:0] w, input logic [15:0] m, input ldm_pkg::ldm_op_t op,
		input logic [3:0] wc);
		ldm_exp_t e;
		rnd = lfsr(rnd);
		e = '{op, wc, op == ldm_pkg::LDM_OP_NONE, rnd[31:16], (w & ~m) | (rnd[15:0] & m)};
		i_mem.prog[n] = e.f;
		n++;
		if (wc[3:2] == 2'h2) begin
			i_mem.prog[n] = rnd[31:16];
			n++;
		end
		expq.push_back(e);
	endtask

	// Compare a result with its note; fields only where the opcode carries them
	task automatic check_dec(input ldm_exp_t e);
		logic [8:0] imm;
		logic [2:0] sel;
		logic [4:0] sh;
		logic imm_use;
		logic sel_use;
		logic sh_use;
		imm_use = e.op inside {ldm_pkg::LDM_OP_LOAD_ACC_IMM, ldm_pkg::LDM_OP_LOAD_AUX_SHORT,
			ldm_pkg::LDM_OP_LOAD_PAGE_IMM};
		imm = (e.op == ldm_pkg::LDM_OP_LOAD_PAGE_IMM) ? e.f[8:0] : {1'b0, e.f[7:0]};
		sel_use = e.op inside {ldm_pkg::LDM_OP_LOAD_AUX_SHORT, ldm_pkg::LDM_OP_LOAD_AUX_LONG,
			ldm_pkg::LDM_OP_LOAD_AUX_PTR};
		sel = (e.op == ldm_pkg::LDM_OP_LOAD_AUX_SHORT) ? e.f[10:8] : e.f[2:0];
		sh_use = e.op inside {ldm_pkg::LDM_OP_OR_SHIFT, ldm_pkg::LDM_OP_OR_SHIFT16};
		sh = (e.op == ldm_pkg::LDM_OP_OR_SHIFT16) ? 5'h10 : {1'b0, e.f[3:0]};
		total_checks++;
		if (dec.op !== e.op || dunk !== e.u || (!e.u && {dec.words, dec.cycles} !== e.wc)
			|| (e.wc[3:2] == 2'h2 && dec.second_word !== e.s)
			|| (!e.u && dec.operand_address_byte !== e.f[7:0])
			|| (imm_use && dec.immediate !== imm) || (sel_use && dec.aux_reg_select !== sel)
			|| (sh_use && dec.shift_count !== sh)) begin
			bad_count++;
			$display("mismatch decode exp %h seen %h %h", e, dec, dunk);
		end
	endtask

	task stop_test();
		$display("checks %0d errors %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Random stalls on both sides
	always @(negedge i_clock) begin
		rnd = lfsr(rnd);
		exec_ready <= rnd[0] | rnd[1];
		stall <= rnd[2] & rnd[3];
	end

	// Take the oldest note for each result handed over
	always @(posedge i_clock) begin
		if (i_nrst && dvalid && exec_ready) begin
			if (expq.size() == 0) begin
				bad_count++;
				$display("mismatch queue exp empty seen %h", dec.op);
			end else
				check_dec(expq.pop_front());
		end
	end

	// Main sequence
	initial begin
		repeat (3) begin
			add(16'hb900, 16'h00ff, ldm_pkg::LDM_OP_LOAD_ACC_IMM, 4'h5);
			add(16'hb900, 16'h0000, ldm_pkg::LDM_OP_LOAD_ACC_IMM, 4'h5);
			add(16'h6a00, 16'h00ff, ldm_pkg::LDM_OP_LOAD_ACC_HIGH, 4'h5);
			add(16'h6900, 16'h00ff, ldm_pkg::LDM_OP_LOAD_ACC_LOW, 4'h5);
			add(16'h6b00, 16'h00ff, ldm_pkg::LDM_OP_LOAD_ACC_TSHIFT, 4'h5);
			add(16'hb000, 16'h07ff, ldm_pkg::LDM_OP_LOAD_AUX_SHORT, 4'h6);
			add(16'hbf08, 16'h0007, ldm_pkg::LDM_OP_LOAD_AUX_LONG, 4'ha);
			add(16'hbc00, 16'h01ff, ldm_pkg::LDM_OP_LOAD_PAGE_IMM, 4'h6);
			add(16'h0d00, 16'h00ff, ldm_pkg::LDM_OP_LOAD_PAGE_MEM, 4'h6);
			add(16'h0e00, 16'h00ff, ldm_pkg::LDM_OP_LOAD_STAT0, 4'h6);
			add(16'h0f00, 16'h00ff, ldm_pkg::LDM_OP_LOAD_STAT1, 4'h6);
			add(16'h7000, 16'h00ff, ldm_pkg::LDM_OP_LOAD_T_ACC, 4'h5);
			add(16'h7200, 16'h00ff, ldm_pkg::LDM_OP_LOAD_T_MOVE, 4'h5);
			add(16'h7100, 16'h00ff, ldm_pkg::LDM_OP_LOAD_T_PROD, 4'h5);
			add(16'h7400, 16'h00ff, ldm_pkg::LDM_OP_LOAD_T_SUB, 4'h5);
			add(16'ha200, 16'h00ff, ldm_pkg::LDM_OP_MUL_ACC, 4'hb);
			add(16'ha300, 16'h00ff, ldm_pkg::LDM_OP_MUL_ACC_MOVE, 4'hb);
			add(16'h8b88, 16'h0007, ldm_pkg::LDM_OP_LOAD_AUX_PTR, 4'h5);
			add(16'h8b00, 16'h0077, ldm_pkg::LDM_OP_MODIFY_AUX, 4'h5);
			add(16'h5400, 16'h00ff, ldm_pkg::LDM_OP_MULTIPLY, 4'h5);
			add(16'h5000, 16'h00ff, ldm_pkg::LDM_OP_MUL_ADD_PREV, 4'h5);
			add(16'h5100, 16'h00ff, ldm_pkg::LDM_OP_MUL_SUB_PREV, 4'h5);
			add(16'ha000, 16'h00ff, ldm_pkg::LDM_OP_NORMALIZE, 4'h5);
			add(16'hbfc0, 16'h000f, ldm_pkg::LDM_OP_OR_SHIFT, 4'ha);
			add(16'hbe82, 16'h0000, ldm_pkg::LDM_OP_OR_SHIFT16, 4'ha);
			add(16'hbe03, 16'h0000, ldm_pkg::LDM_OP_PROD_TO_ACC, 4'h5);
			add(16'h7700, 16'h00ff, ldm_pkg::LDM_OP_NONE, 4'h5);
		end
		repeat (4) @(negedge i_clock);
		i_nrst <= 1'b1;
		count <= n[7:0];
		for (k = 0; k < 3000 && expq.size() > 0; k++)
			@(negedge i_clock);
		if (expq.size() > 0) begin
			bad_count++;
			$display("mismatch timeout exp 0 seen %0d", expq.size());
		end
		stop_test();
	end
endmodule
